// ### verilog/dcc_pkg.sv
// Package: register map, field positions, reset values and timing for dual comparator control
package dcc_pkg;

  // Register offsets on the 8-bit register port
  localparam logic [7:0] OFS_PORT0 = 8'h80;
  localparam logic [7:0] OFS_DIGIN_OFF = 8'hF6;
  localparam logic [7:0] OFS_CMP_ONE = 8'hAC;
  localparam logic [7:0] OFS_CMP_TWO = 8'hAD;
  localparam logic [7:0] OFS_IRQ_EN_ZERO = 8'hA8;
  localparam logic [7:0] OFS_IRQ_EN_ONE = 8'hE8;
  localparam logic [7:0] OFS_TIMING_OPT = 8'hC0;

  // Comparator control register fields
  localparam int CB_FLAG = 0;
  localparam int CB_RES = 1;
  localparam int CB_OE = 2;
  localparam int CB_NEG = 3;
  localparam int CB_POS = 4;
  localparam int CB_EN = 5;
  localparam logic [7:0] CTL_CFG_MASK = 8'h3C;

  // Interrupt enable and option fields
  localparam int IRQ_ENABLE_REG_ZERO_GLOBAL = 7;
  localparam int IRQ_ENABLE_REG_ONE_CMP_ONE = 0;
  localparam int IRQ_ENABLE_REG_ONE_CMP_TWO = 1;
  localparam int OPT_STD = 0;

  // Reset values
  localparam logic [7:0] RST_DIGIN_OFF = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_STD = 1'b0;

  // Oscillator periods per machine cycle
  localparam logic [3:0] MCYC_FAST = 4'h6;
  localparam logic [3:0] MCYC_STD = 4'hC;

  // Picks the compare result for the selected input pair
  function automatic logic cmp_pick(input logic [3:0] raw, input logic pos, input logic neg);
    cmp_pick = raw[{pos, neg}];
  endfunction : cmp_pick

endpackage : dcc_pkg

// ### verilog/dcc_cmp_if.sv
// Interface between the control block and one comparator slice
`timescale 1ns/1ns
interface dcc_cmp_if;
  logic en;
  logic pos_sel;
  logic neg_sel;
  logic result;
  logic change;

  // Control side drives configuration, slice returns result
  modport ctl (output en, output pos_sel, output neg_sel, input result, input change);
  modport cmp (input en, input pos_sel, input neg_sel, output result, output change);
endinterface : dcc_cmp_if

// ### verilog/dcc_comparator.sv
// One comparator slice: synchroniser, input selection, result and change detect
`timescale 1ns/1ns
module dcc_comparator
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw analog compare outcomes: A-pin, A-ref, B-pin, B-ref
  input wire logic [3:0] raw,
  // Control side
  dcc_cmp_if.cmp port
);

  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic res_r;
  logic res_nxt;
  logic chg_r;
  logic chg_nxt;

  // Two-stage synchroniser for the asynchronous analog outcomes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  // Selected pair, disabled slice reads zero; no idle gating
  always_comb begin
    res_nxt = port.en ? cmp_pick(s2_r, port.pos_sel, port.neg_sel) : 1'b0;
    chg_nxt = res_nxt != res_r;
  end

  // Result and change registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_r <= 1'b0;
      chg_r <= 1'b0;
    end else begin
      res_r <= res_nxt;
      chg_r <= chg_nxt;
    end
  end

  assign port.result = res_r;
  assign port.change = chg_r;

endmodule : dcc_comparator

// ### verilog/dcc_top.sv
// Dual comparator control: registers, port 0 input masking, flags, interrupt and cycle timing
// Behaviour
// - Default machine cycle lasts six oscillator periods.
// - Standard timing option stretches machine cycle to twelve periods.
// - Each input-disable bit switches off one port 0 input buffer.
// - Port 0 reads return zero on disabled pins.
// - Result is one when selected positive input exceeds selected negative.
// - Result readable in register and drivable onto a pin.
// - Three control bits give eight configurations per comparator.
// - Any result change in either direction sets the change flag.
// - Interrupt needs flag, comparator interrupt enable and global enable.
// - Enabled comparators keep working in idle and power-down.
// - Enabled change during idle or power-down raises interrupt and wakes.
`timescale 1ns/1ns
module dcc_top
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Processor status and requests
  input wire logic cpu_idle,
  input wire logic cpu_pdown,
  output logic mach_cycle,
  output logic irq_req,
  output logic wake_req,
  // Port 0 pins
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_inbuf_en,
  output logic [7:0] p0_read_data,
  // Analog front end, index 0 is comparator one
  input wire logic [1:0][3:0] cmp_raw,
  output logic [1:0] cmp_enable,
  output logic [1:0] cmp_pos_sel,
  output logic [1:0] cmp_neg_sel,
  // Result pins
  output logic [1:0] cmp_pin_out,
  output logic [1:0] cmp_pin_oe
);

  logic [7:0] off_r;
  logic [7:0] off_nxt;
  logic [1:0][7:0] ctl_r;
  logic [1:0][7:0] ctl_nxt;
  logic ea_r;
  logic ea_nxt;
  logic [1:0] ec_r;
  logic [1:0] ec_nxt;
  logic std_r;
  logic std_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] p0_s1_r;
  logic [7:0] p0_s2_r;
  logic [7:0] p0_rd_r;
  logic [7:0] p0_rd_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] cnt_lim;
  logic mcyc_r;
  logic mcyc_nxt;
  logic [1:0] res;
  logic [1:0] chg;
  logic [1:0] flag;

  // Strobe on a given offset
  function automatic logic acc(input logic stb, input logic [7:0] addr, input logic [7:0] ofs);
    acc = stb && (addr == ofs);
  endfunction : acc

  // Offset of a comparator control register
  function automatic logic [7:0] cmp_ofs(input int idx);
    cmp_ofs = (idx == 0) ? OFS_CMP_ONE : OFS_CMP_TWO;
  endfunction : cmp_ofs

  // Comparator slices
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    dcc_cmp_if cif ();
    assign cif.en = ctl_r[i][CB_EN];
    assign cif.pos_sel = ctl_r[i][CB_POS];
    assign cif.neg_sel = ctl_r[i][CB_NEG];
    assign res[i] = cif.result;
    assign chg[i] = cif.change;
    dcc_comparator u_cmp (
      .clk(clk),
      .nrst(nrst),
      .raw(cmp_raw[i]),
      .port(cif.cmp)
    );
  end

  // Port 0 pin synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p0_s1_r <= 8'h00;
      p0_s2_r <= 8'h00;
    end else begin
      p0_s1_r <= p0_pin_in;
      p0_s2_r <= p0_s1_r;
    end
  end

  // Port 0 read value, disabled pins forced low
  always_comb begin
    p0_rd_nxt = p0_s2_r & ~off_r;
  end

  // Register writes, flag set and clear
  always_comb begin
    off_nxt = off_r;
    ea_nxt = ea_r;
    ec_nxt = ec_r;
    std_nxt = std_r;
    ctl_nxt = ctl_r;
    if (acc(reg_wr, reg_addr, OFS_DIGIN_OFF)) begin
      off_nxt = reg_wdata;
    end
    if (acc(reg_wr, reg_addr, OFS_IRQ_EN_ZERO)) begin
      ea_nxt = reg_wdata[IRQ_ENABLE_REG_ZERO_GLOBAL];
    end
    if (acc(reg_wr, reg_addr, OFS_IRQ_EN_ONE)) begin
      ec_nxt = {reg_wdata[IRQ_ENABLE_REG_ONE_CMP_TWO], reg_wdata[IRQ_ENABLE_REG_ONE_CMP_ONE]};
    end
    if (acc(reg_wr, reg_addr, OFS_TIMING_OPT)) begin
      std_nxt = reg_wdata[OPT_STD];
    end
    for (int i = 0; i < 2; i++) begin
      if (acc(reg_wr, reg_addr, cmp_ofs(i))) begin
        // Config bits load; flag can only be cleared
        ctl_nxt[i] = (reg_wdata & CTL_CFG_MASK) | (ctl_r[i] & ~CTL_CFG_MASK);
        ctl_nxt[i][CB_FLAG] = ctl_r[i][CB_FLAG] & reg_wdata[CB_FLAG];
      end
      // Set wins over a clear in the same cycle
      if (chg[i]) begin
        ctl_nxt[i][CB_FLAG] = 1'b1;
      end
    end
  end

  // Read data, one cycle after the read strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFS_PORT0: rdata_nxt = p0_s2_r & ~off_r;
        OFS_DIGIN_OFF: rdata_nxt = off_r;
        OFS_CMP_ONE: begin
          rdata_nxt = ctl_r[0];
          rdata_nxt[CB_RES] = res[0];
        end
        OFS_CMP_TWO: begin
          rdata_nxt = ctl_r[1];
          rdata_nxt[CB_RES] = res[1];
        end
        OFS_IRQ_EN_ZERO: rdata_nxt[IRQ_ENABLE_REG_ZERO_GLOBAL] = ea_r;
        OFS_IRQ_EN_ONE: begin
          rdata_nxt[IRQ_ENABLE_REG_ONE_CMP_ONE] = ec_r[0];
          rdata_nxt[IRQ_ENABLE_REG_ONE_CMP_TWO] = ec_r[1];
        end
        OFS_TIMING_OPT: rdata_nxt[OPT_STD] = std_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Machine cycle divider, 6 or 12 oscillator periods
  always_comb begin
    cnt_lim = std_r ? (MCYC_STD - 4'h1) : (MCYC_FAST - 4'h1);
    mcyc_nxt = cnt_r >= cnt_lim;
    cnt_nxt = mcyc_nxt ? 4'h0 : 4'(cnt_r + 4'h1);
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      off_r <= RST_DIGIN_OFF;
      ctl_r <= {RST_CTL, RST_CTL};
      ea_r <= RST_IRQ_EN;
      ec_r <= {RST_IRQ_EN, RST_IRQ_EN};
      std_r <= RST_STD;
      rdata_r <= 8'h00;
      p0_rd_r <= 8'h00;
      cnt_r <= 4'h0;
      mcyc_r <= 1'b0;
    end else begin
      off_r <= off_nxt;
      ctl_r <= ctl_nxt;
      ea_r <= ea_nxt;
      ec_r <= ec_nxt;
      std_r <= std_nxt;
      rdata_r <= rdata_nxt;
      p0_rd_r <= p0_rd_nxt;
      cnt_r <= cnt_nxt;
      mcyc_r <= mcyc_nxt;
    end
  end

  // Flags and interrupt request
  assign flag = {ctl_r[1][CB_FLAG], ctl_r[0][CB_FLAG]};
  assign irq_req = ea_r && |(flag & ec_r);
  assign wake_req = irq_req && (cpu_idle || cpu_pdown);

  // Outputs
  assign reg_rdata = rdata_r;
  assign mach_cycle = mcyc_r;
  assign p0_inbuf_en = ~off_r;
  assign p0_read_data = p0_rd_r;
  assign cmp_enable = {ctl_r[1][CB_EN], ctl_r[0][CB_EN]};
  assign cmp_pos_sel = {ctl_r[1][CB_POS], ctl_r[0][CB_POS]};
  assign cmp_neg_sel = {ctl_r[1][CB_NEG], ctl_r[0][CB_NEG]};
  assign cmp_pin_out = res;
  assign cmp_pin_oe = cmp_enable & {ctl_r[1][CB_OE], ctl_r[0][CB_OE]};

  // Checks: machine cycle timing
  sequence fast_run;
    (mcyc_r && !std_r) ##1 (!std_r)[*5];
  endsequence

  sequence slow_run;
    (mcyc_r && std_r) ##1 std_r[*8] ##1 std_r[*3];
  endsequence

  chk_mcyc_fast: assert property (
    @(posedge clk) disable iff (!nrst) fast_run |=> mcyc_r)
    else $error("Fast machine cycle is not six periods");

  chk_mcyc_gap: assert property (
    @(posedge clk) disable iff (!nrst) mcyc_r |=> !mcyc_r [*5])
    else $error("Machine cycle pulses closer than six periods");

  chk_mcyc_slow: assert property (
    @(posedge clk) disable iff (!nrst) slow_run |=> mcyc_r)
    else $error("Standard machine cycle is not twelve periods");

  // Checks: port 0 masking
  chk_inbuf_write: assert property (
    @(posedge clk) disable iff (!nrst)
    acc(reg_wr, reg_addr, OFS_DIGIN_OFF) |=> p0_inbuf_en == ~$past(reg_wdata))
    else $error("Input buffer enables do not follow written value");

  chk_inbuf_hold: assert property (
    @(posedge clk) disable iff (!nrst) !acc(reg_wr, reg_addr, OFS_DIGIN_OFF) |=> $stable(p0_inbuf_en))
    else $error("Input buffer enables moved without a write");

  chk_p0_masked: assert property (
    @(posedge clk) disable iff (!nrst)
    acc(reg_rd, reg_addr, OFS_PORT0) |=> (reg_rdata & $past(off_r)) == 8'h00)
    else $error("Disabled port 0 pin read as one");

  chk_p0_data: assert property (
    @(posedge clk) disable iff (!nrst) 1'b1 |=> (p0_read_data & $past(off_r)) == 8'h00)
    else $error("Port 0 data shows a disabled pin");

  // Checks: comparator result selection
  chk_res_pick: assert property (
    @(posedge clk) disable iff (!nrst) ctl_r[0][CB_EN] |=>
    res[0] == cmp_pick($past(cmp_raw[0], 3), $past(ctl_r[0][CB_POS]), $past(ctl_r[0][CB_NEG])))
    else $error("Comparator one result does not follow selected inputs");

  chk_res_pick_two: assert property (
    @(posedge clk) disable iff (!nrst) ctl_r[1][CB_EN] |=>
    res[1] == cmp_pick($past(cmp_raw[1], 3), $past(ctl_r[1][CB_POS]), $past(ctl_r[1][CB_NEG])))
    else $error("Comparator two result does not follow selected inputs");

  chk_res_off: assert property (
    @(posedge clk) disable iff (!nrst) !ctl_r[1][CB_EN] |-> !cmp_pin_oe[1] ##1 !res[1])
    else $error("Disabled comparator two shows a result");

  chk_res_read: assert property (
    @(posedge clk) disable iff (!nrst)
    acc(reg_rd, reg_addr, OFS_CMP_ONE) |=> reg_rdata[CB_RES] == $past(res[0]))
    else $error("Result bit read back wrong");

  // Checks: comparator configuration
  chk_cfg_load: assert property (
    @(posedge clk) disable iff (!nrst)
    acc(reg_wr, reg_addr, OFS_CMP_ONE) |=> (ctl_r[0] & CTL_CFG_MASK) == ($past(reg_wdata) & CTL_CFG_MASK))
    else $error("Comparator one configuration did not load");

  chk_cfg_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    !acc(reg_wr, reg_addr, OFS_CMP_TWO) |=> (ctl_r[1] & CTL_CFG_MASK) == ($past(ctl_r[1]) & CTL_CFG_MASK))
    else $error("Comparator two configuration moved without a write");

  // Checks: change flag and interrupt
  chk_flag_set: assert property (
    @(posedge clk) disable iff (!nrst) $changed(res[0]) |=> flag[0])
    else $error("Result change did not set flag");

  chk_flag_set_two: assert property (
    @(posedge clk) disable iff (!nrst) $changed(res[1]) |=> flag[1])
    else $error("Comparator two result change did not set flag");

  chk_flag_clear: assert property (
    @(posedge clk) disable iff (!nrst)
    acc(reg_wr, reg_addr, OFS_CMP_ONE) && !reg_wdata[CB_FLAG] && !chg[0] |=> !flag[0])
    else $error("Writing zero did not clear the flag");

  chk_flag_keep: assert property (
    @(posedge clk) disable iff (!nrst)
    acc(reg_wr, reg_addr, OFS_CMP_ONE) && reg_wdata[CB_FLAG] && flag[0] |=> flag[0])
    else $error("Writing one cleared the flag");

  chk_flag_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    flag[1] && !acc(reg_wr, reg_addr, OFS_CMP_TWO) |=> flag[1])
    else $error("Flag cleared without a write");

  chk_irq_gate: assert property (
    @(posedge clk) disable iff (!nrst) irq_req |-> ea_r && ((flag[0] && ec_r[0]) || (flag[1] && ec_r[1])))
    else $error("Interrupt raised without flag and enables");

  chk_wake: assert property (
    @(posedge clk) disable iff (!nrst)
    chg[0] && ec_r[0] && ea_r && !reg_wr && cpu_idle ##1 cpu_idle |-> wake_req && irq_req)
    else $error("Change in idle did not wake the processor");

  chk_irq_raise: assert property (
    @(posedge clk) disable iff (!nrst) chg[0] && ec_r[0] && ea_r && !reg_wr |=> irq_req)
    else $error("Flag set with enables did not raise interrupt");

  // Change seen while powered down, power-down held one more cycle
  sequence pdown_flip;
    (chg[0] && ec_r[0] && ea_r && !reg_wr && cpu_pdown) ##1 cpu_pdown;
  endsequence

  chk_pdown_wake: assert property (
    @(posedge clk) disable iff (!nrst) pdown_flip |-> wake_req && irq_req)
    else $error("Change in power-down did not wake the processor");

  chk_wake_quiet: assert property (
    @(posedge clk) disable iff (!nrst) !cpu_idle && !cpu_pdown |-> !wake_req)
    else $error("Wake request while the processor runs");

endmodule : dcc_top

// ### verif/dcc_analog_model.sv
// Behavioural model of the comparator input pins and internal reference
`timescale 1ns/1ns
module dcc_analog_model #(
  parameter int REF_LVL = 50
) (
  // Pin levels per comparator, index 0 is comparator one
  input wire logic [1:0][7:0] lvl_pos_a,
  input wire logic [1:0][7:0] lvl_pos_b,
  input wire logic [1:0][7:0] lvl_neg_pin,
  // Raw compare outcomes toward the block
  output logic [1:0][3:0] cmp_raw
);
  // Analog compares never stop, enabled or not, idle or not
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cmp_raw[c][0] = lvl_pos_a[c] > lvl_neg_pin[c];
      cmp_raw[c][1] = lvl_pos_a[c] > REF_LVL[7:0];
      cmp_raw[c][2] = lvl_pos_b[c] > lvl_neg_pin[c];
      cmp_raw[c][3] = lvl_pos_b[c] > REF_LVL[7:0];
    end
  end
endmodule : dcc_analog_model

// ### verif/tb_dual_comparator_control.sv
// Self-checking testbench for the dual comparator control block
`timescale 1ns/1ns
module tb_dual_comparator_control;
  import dcc_pkg::*;
  localparam int REF_LVL = 50;
  localparam int SETTLE_CYC = 2500; // Ten microseconds of 4 ns clocks
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_idle = 1'b0, cpu_pdown = 1'b0;
  logic mach_cycle, irq_req, wake_req;
  logic [7:0] p0_pin_in = 8'h00, p0_inbuf_en, p0_read_data;
  logic [1:0][3:0] cmp_raw;
  logic [1:0] cmp_enable, cmp_pos_sel, cmp_neg_sel, cmp_pin_out, cmp_pin_oe;
  logic [1:0][7:0] lvl_a = '0, lvl_b = '0, lvl_n = '0;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] rv;
  logic exp_res;

  // Oscillator, 4 ns period
  always #2 clk = ~clk;

  dcc_top u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .cpu_pdown(cpu_pdown),
    .mach_cycle(mach_cycle), .irq_req(irq_req), .wake_req(wake_req), .p0_pin_in(p0_pin_in),
    .p0_inbuf_en(p0_inbuf_en), .p0_read_data(p0_read_data), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
    .cmp_pos_sel(cmp_pos_sel), .cmp_neg_sel(cmp_neg_sel), .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe));

  dcc_analog_model #(.REF_LVL(REF_LVL)) u_analog (.lvl_pos_a(lvl_a), .lvl_pos_b(lvl_b), .lvl_neg_pin(lvl_n),
    .cmp_raw(cmp_raw));

  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Bounded wait for a machine cycle tick, returns clocks waited
  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
      if (n > 40) begin
        err_total++;
        $display("mismatch mach_cycle expected tick seen none");
        conclude();
      end
    end while (mach_cycle !== 1'b1);
  endtask : tick_gap

  initial begin
    int gap;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    #1;
    // Reset state
    chk("inbuf_en", p0_inbuf_en, 8'hFF);
    chk("irq", {7'h0, irq_req}, 8'h00);
    rd(OFS_DIGIN_OFF, rv); chk("digin_off", rv, RST_DIGIN_OFF);
    rd(OFS_CMP_ONE, rv); chk("ctl_one", rv, RST_CTL);
    rd(8'h5A, rv); chk("unmapped", rv, 8'h00);
    // Machine cycle length in both timings
    tick_gap(gap); tick_gap(gap); chk("fast_gap", gap[7:0], {4'h0, MCYC_FAST});
    wr(OFS_TIMING_OPT, 8'h01);
    tick_gap(gap); tick_gap(gap); chk("std_gap", gap[7:0], {4'h0, MCYC_STD});
    wr(OFS_TIMING_OPT, 8'h00);
    // Port 0 input disable masks reads
    p0_pin_in <= 8'hFF;
    wr(OFS_DIGIN_OFF, 8'h30);
    wr(OFS_PORT0, 8'h00);
    cyc(4);
    chk("inbuf_en", p0_inbuf_en, 8'hCF);
    chk("p0_data", p0_read_data, 8'hCF);
    rd(OFS_PORT0, rv); chk("p0_read", rv, 8'hCF);
    rd(OFS_DIGIN_OFF, rv); chk("digin_off", rv, 8'h30);
    // Comparator one: enable, settle, clear flag, interrupt on falling change
    lvl_a[0] <= 8'd100;
    lvl_n[0] <= 8'd60;
    wr(OFS_CMP_ONE, 8'h24);
    cyc(8);
    chk("pin_out", {4'h0, cmp_pin_oe, cmp_pin_out}, 8'h05);
    rd(OFS_CMP_ONE, rv); chk("ctl_one", rv, 8'h27);
    cyc(SETTLE_CYC);
    wr(OFS_CMP_ONE, 8'hE5);
    rd(OFS_CMP_ONE, rv); chk("ctl_keep", rv, 8'h27);
    wr(OFS_CMP_ONE, 8'hE4);
    rd(OFS_CMP_ONE, rv); chk("ctl_clear", rv, 8'h26);
    wr(OFS_IRQ_EN_ONE, 8'h01);
    wr(OFS_IRQ_EN_ZERO, 8'h80);
    cyc(1);
    chk("irq_quiet", {7'h0, irq_req}, 8'h00);
    @(posedge clk);
    cpu_pdown <= 1'b1;
    lvl_a[0] <= 8'd40;
    cyc(6);
    chk("irq_set", {6'h0, wake_req, irq_req}, 8'h03);
    chk("pin_out", {7'h0, cmp_pin_out[0]}, 8'h00);
    cyc(20);
    rd(OFS_CMP_ONE, rv); chk("flag_held", rv, 8'h25);
    wr(OFS_IRQ_EN_ZERO, 8'h00);
    cyc(1);
    chk("irq_global", {7'h0, irq_req}, 8'h00);
    wr(OFS_IRQ_EN_ZERO, 8'h80);
    wr(OFS_IRQ_EN_ONE, 8'h00);
    cyc(1);
    chk("irq_local", {7'h0, irq_req}, 8'h00);
    wr(OFS_IRQ_EN_ONE, 8'h01);
    cyc(1);
    chk("irq_back", {7'h0, irq_req}, 8'h01);
    wr(OFS_CMP_ONE, 8'h24);
    cyc(1);
    chk("irq_clear", {6'h0, wake_req, irq_req}, 8'h00);
    @(posedge clk);
    cpu_pdown <= 1'b0;
    cpu_idle <= 1'b1;
    lvl_a[0] <= 8'd100;
    cyc(6);
    chk("idle_wake", {6'h0, wake_req, irq_req}, 8'h03);
    @(posedge clk);
    cpu_idle <= 1'b0;
    // Comparator two: all eight configurations
    lvl_a[1] <= 8'd100;
    lvl_b[1] <= 8'd70;
    lvl_n[1] <= 8'd80;
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CMP_TWO, 8'h20 | 8'(k << 2));
      if (k == 0) cyc(SETTLE_CYC);
      cyc(6);
      exp_res = ((k & 4) != 0) ? (70 > (((k & 2) != 0) ? REF_LVL : 80)) : (100 > (((k & 2) != 0) ? REF_LVL : 80));
      chk("sel_two", {4'h0, cmp_enable[1], cmp_pos_sel[1], cmp_neg_sel[1], cmp_pin_oe[1]},
        {4'h0, 1'b1, k[2], k[1], k[0]});
      chk("res_two", {7'h0, cmp_pin_out[1]}, {7'h0, exp_res});
      rd(OFS_CMP_TWO, rv); chk("res_reg", {7'h0, rv[CB_RES]}, {7'h0, exp_res});
    end
    conclude();
  end
endmodule : tb_dual_comparator_control
